/* File: logic/llsh_handler.sv */
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "llsh_regs.svh"
module llsh_handler
    import llsh_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output      logic [31:0] prdata,
    output      logic        pready,
    output      logic        pslverr,
    input  wire logic        req_valid,
    input  wire logic [31:0] req_data,
    input  wire logic        req_last,
    output      logic        req_ready,
    output      logic        rsp_valid,
    output      logic [31:0] rsp_data,
    output      logic        rsp_last,
    output      logic        rsp_reject,
    output      logic [1:0]  rsp_reason,
    input  wire logic        rsp_ready,
    output      logic        lip_req,
    output      logic        lip_login,
    output      logic [7:0]  lip_byte3,
    output      logic [7:0]  lip_byte4,
    input  wire logic        port_monitoring,
    input  wire logic        fan_busy,
    input  wire logic        init_fail
);

    llsh_top_t q;
    llsh_top_t d;

    logic                      apb_wr;
    logic                      apb_rd;
    logic                      db_hit;
    logic [`LLSH_DB_IDX_W-1:0] db_apb_idx;
    logic [31:0]               db_apb_data;
    logic [`LLSH_DB_IDX_W-1:0] db_rsp_idx;
    logic [31:0]               db_rsp_data;
    logic [5:0]                next_idx;

    function automatic logic [7:0] cur_loop_state(input llsh_top_t s);
        // while our own initialization runs the loop is reported initializing
        if (s.st == LLSH_S_LIP || s.st == LLSH_S_WOPEN || s.st == LLSH_S_WMON) begin
            return `LLSH_LS_INITING;
        end
        return s.loop[`LLSH_LOOP_STATE_LSB +: 8];
    endfunction

    // one reply word; db is the database word that belongs to this index
    function automatic logic [31:0] reply_word(input llsh_top_t s, input logic [5:0] i,
                                               input logic [31:0] db);
        logic [7:0] ls;
        logic [7:0] fr;
        ls = cur_loop_state(s);
        fr = (ls == `LLSH_LS_FAILURE) ? s.loop[`LLSH_LOOP_FR_LSB +: 8] : 8'h00;
        if (s.rjt) begin
            return 32'h0000_0000;
        end
        if (i == 6'd0) begin
            return {`LLSH_ACC_CODE, 24'h00_0000};
        end
        if (s.is_linit) begin
            return {24'h00_0000, s.list_status};
        end
        if (i == 6'd1) begin
            return {8'h00, fr, 8'h00, ls};
        end
        // bitmaps and position map are only sent while online, zeros mean no map
        if (ls != `LLSH_LS_ONLINE) begin
            return 32'h0000_0000;
        end
        return db;
    endfunction

    function automatic logic [5:0] db_index(input logic [5:0] i);
        return (i >= `LLSH_DB_FIRST_WORD) ? 6'(i - `LLSH_DB_FIRST_WORD) : 6'd0;
    endfunction

    assign apb_wr     = psel && penable && pwrite && !q.pready;
    assign apb_rd     = psel && penable && !pwrite && !q.pready;
    assign db_hit     = paddr >= `LLSH_ADDR_DB_LO && paddr <= `LLSH_ADDR_DB_HI;
    assign db_apb_idx = 6'((paddr - `LLSH_ADDR_DB_LO) >> `LLSH_DB_IDX_LSB);
    assign next_idx   = 6'(q.idx + 6'd1);
    assign db_rsp_idx = db_index((q.st == LLSH_S_REPLY) ? next_idx : 6'd0);

    llsh_loop_db u_db (
        .pclk      (pclk),
        .presetn   (presetn),
        .wr_en     (apb_wr && db_hit && paddr[1:0] == 2'b00),
        .wr_idx    (db_apb_idx),
        .wr_data   (pwdata),
        .rd_a_idx  (db_apb_idx),
        .rd_a_data (db_apb_data),
        .rd_b_idx  (db_rsp_idx),
        .rd_b_data (db_rsp_data)
    );

    always_comb begin
        d = q;
        d.lip.req = 1'b0;

        // apb slave: three-cycle access (one wait state), pready from a flop
        d.pready  = apb_wr || apb_rd;
        d.pslverr = 1'b0;
        if (apb_wr || apb_rd) begin
            d.prdata = 32'h0000_0000;
            if (paddr[1:0] != 2'b00) begin
                d.pslverr = 1'b1;
            end else if (paddr == `LLSH_ADDR_CTRL) begin
                d.prdata = q.ctrl;
                if (apb_wr) begin
                    d.ctrl = {30'h0, pwdata[`LLSH_CTRL_LSTS_EN], pwdata[`LLSH_CTRL_FLPORT]};
                end
            end else if (paddr == `LLSH_ADDR_STATUS) begin
                d.prdata = {8'h00, q.rjt_cnt, q.acc_cnt, 4'h0, q.req_ready, q.st};
            end else if (paddr == `LLSH_ADDR_LOOP) begin
                d.prdata = q.loop;
                if (apb_wr) begin
                    d.loop = {16'h0000, pwdata[15:0]};
                end
            end else if (db_hit) begin
                d.prdata = db_apb_data;
            end else begin
                d.pslverr = 1'b1;
            end
        end

        case (q.st)
            LLSH_S_IDLE: begin
                if (req_valid && q.req_ready) begin
                    // words past the second are drained and ignored
                    if (q.wcnt == 2'd0) begin
                        d.w0 = req_data;
                    end else if (q.wcnt == 2'd1) begin
                        d.w1 = req_data;
                    end
                    if (q.wcnt != 2'd3) begin
                        d.wcnt = 2'(q.wcnt + 2'd1);
                    end
                    if (req_last) begin
                        d.st = LLSH_S_EXEC;
                    end
                end
            end
            LLSH_S_EXEC: begin
                d.idx      = 6'd0;
                d.rjt      = 1'b0;
                d.is_linit = 1'b0;
                d.len      = `LLSH_LEN_RJT;
                d.st       = LLSH_S_REPLY;
                // only the command byte is decoded, reserved bytes are ignored
                if (q.w0[31:24] == `LLSH_CMD_LINIT) begin
                    d.is_linit = 1'b1;
                    if (!q.ctrl[`LLSH_CTRL_FLPORT]) begin
                        d.rjt    = 1'b1;
                        d.reason = `LLSH_RSN_UNSUPP;
                    end else if (q.wcnt < 2'd2) begin
                        d.rjt    = 1'b1;
                        d.reason = `LLSH_RSN_SHORT;
                    end else if (q.w1[23:16] != `LLSH_FUNC_NORMAL &&
                                 q.w1[23:16] != `LLSH_FUNC_LOGIN) begin
                        d.rjt    = 1'b1;
                        d.reason = `LLSH_RSN_BADFUNC;
                    end else begin
                        d.lip.login = (q.w1[23:16] == `LLSH_FUNC_LOGIN);
                        d.lip.byte3 = q.w1[15:8];
                        d.lip.byte4 = q.w1[7:0];
                        d.st        = LLSH_S_LIP;
                    end
                end else if (q.w0[31:24] == `LLSH_CMD_LSTS &&
                             q.ctrl[`LLSH_CTRL_LSTS_EN]) begin
                    d.len = `LLSH_LEN_LSTS;
                end else begin
                    d.rjt    = 1'b1;
                    d.reason = `LLSH_RSN_UNSUPP;
                end
            end
            LLSH_S_LIP: begin
                d.lip.req = 1'b1;
                d.st      = LLSH_S_WOPEN;
            end
            LLSH_S_WOPEN: begin
                // the port must first leave monitoring, otherwise a stale level would accept
                if (init_fail) begin
                    d.list_status = `LLSH_LIST_FAIL;
                    d.st          = LLSH_S_REPLY;
                end else if (!port_monitoring) begin
                    d.st = LLSH_S_WMON;
                end
            end
            LLSH_S_WMON: begin
                if (init_fail) begin
                    d.list_status = `LLSH_LIST_FAIL;
                    d.st          = LLSH_S_REPLY;
                end else if (port_monitoring && !fan_busy) begin
                    d.list_status = `LLSH_LIST_OK;
                    d.st          = LLSH_S_REPLY;
                end
            end
            LLSH_S_REPLY: begin
                if (!q.rsp.valid) begin
                    d.len       = q.is_linit && !q.rjt ? `LLSH_LEN_LINIT : q.len;
                    d.rsp.valid = 1'b1;
                    d.rsp.data  = reply_word(q, 6'd0, db_rsp_data);
                    d.rsp.last  = q.rjt || (q.len == 6'd1 && !q.is_linit);
                    d.rsp.reject = q.rjt;
                    d.rsp.reason = q.rjt ? q.reason : 2'h0;
                    if (q.is_linit && !q.rjt) begin
                        // hardware outcome of the initialization wins over a software write
                        d.loop[`LLSH_LOOP_STATE_LSB +: 8] =
                            (q.list_status == `LLSH_LIST_OK) ? `LLSH_LS_ONLINE
                                                             : `LLSH_LS_INITFAIL;
                    end
                end else if (rsp_ready) begin
                    if (q.rsp.last) begin
                        d.rsp.valid = 1'b0;
                        d.rsp.last  = 1'b0;
                        d.rsp.reject = 1'b0;
                        d.wcnt      = 2'd0;
                        d.st        = LLSH_S_IDLE;
                        if (q.rjt) begin
                            d.rjt_cnt = 8'(q.rjt_cnt + 8'd1);
                        end else begin
                            d.acc_cnt = 8'(q.acc_cnt + 8'd1);
                        end
                    end else begin
                        d.idx      = next_idx;
                        d.rsp.data = reply_word(q, next_idx, db_rsp_data);
                        d.rsp.last = (6'(next_idx + 6'd1) == q.len);
                    end
                end
            end
            default: begin
                d.st = LLSH_S_IDLE;
            end
        endcase

        d.req_ready = (d.st == LLSH_S_IDLE);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q         <= '0;
            q.st      <= LLSH_S_IDLE;
            q.ctrl    <= `LLSH_CTRL_RST;
            q.loop    <= `LLSH_LOOP_RST;
            q.req_ready <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign prdata     = q.prdata;
    assign pready     = q.pready;
    assign pslverr    = q.pslverr;
    assign req_ready  = q.req_ready;
    assign rsp_valid  = q.rsp.valid;
    assign rsp_data   = q.rsp.data;
    assign rsp_last   = q.rsp.last;
    assign rsp_reject = q.rsp.reject;
    assign rsp_reason = q.rsp.reason;
    assign lip_req    = q.lip.req;
    assign lip_login  = q.lip.login;
    assign lip_byte3  = q.lip.byte3;
    assign lip_byte4  = q.lip.byte4;

endmodule
`default_nettype wire

/* File: inc/llsh_regs.svh */
`ifndef LLSH_REGS_SVH
`define LLSH_REGS_SVH

// apb byte addresses
`define LLSH_ADDR_CTRL      12'h000
`define LLSH_ADDR_STATUS    12'h004
`define LLSH_ADDR_LOOP      12'h008
`define LLSH_ADDR_DB_LO     12'h100
`define LLSH_ADDR_DB_HI     12'h19c
`define LLSH_DB_IDX_LSB     2
`define LLSH_DB_IDX_W       6

// control register fields and reset value
`define LLSH_CTRL_FLPORT    0
`define LLSH_CTRL_LSTS_EN   1
`define LLSH_CTRL_RST       32'h0000_0003

// loop register fields
`define LLSH_LOOP_STATE_LSB 0
`define LLSH_LOOP_FR_LSB    8
`define LLSH_LOOP_RST       32'h0000_0001

// command codes and reply words
`define LLSH_CMD_LINIT      8'h70
`define LLSH_CMD_LSTS       8'h72
`define LLSH_ACC_CODE       8'h02
`define LLSH_FUNC_NORMAL    8'h00
`define LLSH_FUNC_LOGIN     8'h01
`define LLSH_LIST_OK        8'h01
`define LLSH_LIST_FAIL      8'h02

// loop state byte values
`define LLSH_LS_ONLINE      8'h01
`define LLSH_LS_FAILURE     8'h02
`define LLSH_LS_INITFAIL    8'h03
`define LLSH_LS_INITING     8'h04

// reply lengths in words, first loop database word of the reply
`define LLSH_LEN_LINIT      6'd2
`define LLSH_LEN_LSTS       6'd42
`define LLSH_LEN_RJT        6'd1
`define LLSH_DB_FIRST_WORD  6'd2
`define LLSH_DB_WORDS       40
`define LLSH_PMAP_FIRST     6'd8

// reject reason codes presented to the frame builder
`define LLSH_RSN_UNSUPP     2'h1
`define LLSH_RSN_BADFUNC    2'h2
`define LLSH_RSN_SHORT      2'h3

`endif

/* File: inc/llsh_pkg.sv */
`include "llsh_regs.svh"
package llsh_pkg;

    typedef enum logic [2:0] {
        LLSH_S_IDLE  = 3'h0,
        LLSH_S_EXEC  = 3'h1,
        LLSH_S_LIP   = 3'h3,
        LLSH_S_WOPEN = 3'h2,
        LLSH_S_WMON  = 3'h6,
        LLSH_S_REPLY = 3'h7
    } llsh_state_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] data;
        logic        last;
    } llsh_word_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] data;
        logic        last;
        logic        reject;
        logic [1:0]  reason;
    } llsh_reply_t;

    typedef struct packed {
        logic        req;
        logic        login;
        logic [7:0]  byte3;
        logic [7:0]  byte4;
    } llsh_lip_t;

    typedef struct packed {
        logic [`LLSH_DB_WORDS-1:0][31:0] words;
    } llsh_db_t;

    typedef struct packed {
        llsh_state_t st;
        logic [1:0]  wcnt;
        logic [31:0] w0;
        logic [31:0] w1;
        logic [5:0]  idx;
        logic [5:0]  len;
        logic        rjt;
        logic [1:0]  reason;
        logic [7:0]  list_status;
        logic        is_linit;
        logic        req_ready;
        llsh_reply_t rsp;
        llsh_lip_t   lip;
        logic [31:0] ctrl;
        logic [31:0] loop;
        logic [7:0]  acc_cnt;
        logic [7:0]  rjt_cnt;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } llsh_top_t;

endpackage

/* File: logic/llsh_loop_db.sv */
`timescale 1ns/1ps
`default_nettype none
`include "llsh_regs.svh"
// loop database: public and private device bitmaps, then the position map
module llsh_loop_db
    import llsh_pkg::*;
(
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       wr_en,
    input  wire logic [`LLSH_DB_IDX_W-1:0]  wr_idx,
    input  wire logic [31:0]                wr_data,
    input  wire logic [`LLSH_DB_IDX_W-1:0]  rd_a_idx,
    output      logic [31:0]                rd_a_data,
    input  wire logic [`LLSH_DB_IDX_W-1:0]  rd_b_idx,
    output      logic [31:0]                rd_b_data
);

    llsh_db_t db_q;
    llsh_db_t db_d;

    always_comb begin
        db_d = db_q;
        if (wr_en && wr_idx < `LLSH_DB_IDX_W'(`LLSH_DB_WORDS)) begin
            db_d.words[wr_idx] = wr_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            db_q <= '0;
        end else begin
            db_q <= db_d;
        end
    end

    // out of range reads return zero rather than wrapping
    assign rd_a_data = (rd_a_idx < `LLSH_DB_IDX_W'(`LLSH_DB_WORDS)) ? db_q.words[rd_a_idx] : '0;
    assign rd_b_data = (rd_b_idx < `LLSH_DB_IDX_W'(`LLSH_DB_WORDS)) ? db_q.words[rd_b_idx] : '0;

endmodule
`default_nettype wire

/* File: dv/llsh_handler_props.sv */
`timescale 1ns/1ps
`default_nettype none
module llsh_handler_props
    import llsh_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        req_valid,
    input wire logic [31:0] req_data,
    input wire logic        req_last,
    input wire logic        req_ready,
    input wire logic        rsp_valid,
    input wire logic [31:0] rsp_data,
    input wire logic        rsp_last,
    input wire logic        rsp_reject,
    input wire logic        rsp_ready,
    input wire logic        lip_req,
    input wire logic        lip_login,
    input wire logic [7:0]  lip_byte3,
    input wire logic [7:0]  lip_byte4,
    input wire logic        port_monitoring,
    input wire logic        fan_busy,
    input wire logic        init_fail
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // open initialize: from the primitive pulse until its reply has gone
    logic pend_q;
    logic pend_d;
    always_comb pend_d = lip_req || (pend_q && !(rsp_valid && rsp_ready && rsp_last));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            pend_q <= 1'b0;
        else
            pend_q <= pend_d;
    end

    sequence s_last_taken;
        req_valid && req_ready && req_last;
    endsequence
    sequence s_status_req;
        s_last_taken ##0 req_data == 32'h7200_0000;
    endsequence

    property p_apb_answer;
        psel && penable && !pready |=> pready;
    endproperty
    property p_lip_pulse;
        lip_req |=> !lip_req;
    endproperty
    property p_lip_cause;
        lip_req |-> $past(req_valid && req_ready && req_last, 3)
            && lip_byte3 == $past(req_data[15:8], 3) && lip_byte4 == $past(req_data[7:0], 3);
    endproperty
    property p_lip_login;
        lip_req |-> lip_login == ($past(req_data[23:16], 3) == 8'h01);
    endproperty
    property p_linit_hold;
        pend_q && $rose(rsp_valid) |-> init_fail || (port_monitoring && !fan_busy);
    endproperty
    property p_linit_first;
        pend_q && $rose(rsp_valid) |-> rsp_data == 32'h0200_0000 && !rsp_last && !rsp_reject;
    endproperty
    property p_linit_status;
        pend_q && rsp_valid && rsp_last |-> rsp_data == {24'h0, init_fail ? 8'h02 : 8'h01};
    endproperty
    property p_rsp_hold;
        rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data) && $stable(rsp_last);
    endproperty
    property p_reject_word;
        rsp_valid && rsp_reject |-> rsp_last && rsp_data == 32'h0 && !pend_q;
    endproperty
    property p_status_reply;
        s_status_req |-> ##3 rsp_valid && (rsp_reject || rsp_data == 32'h0200_0000);
    endproperty

    a_apb_answer: assert property (p_apb_answer) else $error("apb answer late");
    a_lip_pulse: assert property (p_lip_pulse) else $error("lip pulse too long");
    a_lip_cause: assert property (p_lip_cause) else $error("lip bytes wrong");
    a_lip_login: assert property (p_lip_login) else $error("login bit wrong");
    a_linit_hold: assert property (p_linit_hold) else $error("accept too early");
    a_linit_first: assert property (p_linit_first) else $error("accept word0 bad");
    a_linit_status: assert property (p_linit_status) else $error("status bad");
    a_rsp_hold: assert property (p_rsp_hold) else $error("reply word not held");
    a_reject_word: assert property (p_reject_word) else $error("reject bad");
    a_status_reply: assert property (p_status_reply) else $error("status late");
endmodule
bind llsh_handler llsh_handler_props i_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
    .req_valid(req_valid), .req_data(req_data), .req_last(req_last), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_last(rsp_last),
    .rsp_reject(rsp_reject), .rsp_ready(rsp_ready), .lip_req(lip_req), .lip_login(lip_login),
    .lip_byte3(lip_byte3), .lip_byte4(lip_byte4), .port_monitoring(port_monitoring),
    .fan_busy(fan_busy), .init_fail(init_fail)
);
`default_nettype wire

/* File: dv/llsh_req_model.sv */
`timescale 1ns/1ps
`default_nettype none
// requesting port: sends request words, takes reply words, may stall the reply
module llsh_req_model
    import llsh_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        req_ready,
    output var  logic        req_valid,
    output var  logic [31:0] req_data,
    output var  logic        req_last,
    input  wire logic        rsp_valid,
    input  wire logic [31:0] rsp_data,
    input  wire logic        rsp_last,
    input  wire logic        rsp_reject,
    input  wire logic [1:0]  rsp_reason,
    output var  logic        rsp_ready
);
    logic [31:0] q[$];
    logic        rj;
    logic [1:0]  rr;
    logic        tmo;
    initial begin
        req_valid = 1'b0;
        req_data  = 32'h0;
        req_last  = 1'b0;
        rsp_ready = 1'b0;
        tmo       = 1'b0;
    end
    // ids ride in the frame header, outside this port
    task automatic send(input logic [31:0] w0, input logic [31:0] w1, input int n);
        int k;
        for (int i = 0; i < n; i++) begin
            req_valid <= 1'b1;
            req_data  <= (i == 0) ? w0 : w1;
            req_last  <= (i == n - 1);
            k = 0;
            do begin
                @(posedge pclk);
                k++;
            end while (req_ready !== 1'b1 && k < 200);
            if (k >= 200)
                tmo = 1'b1;
        end
        req_valid <= 1'b0;
        req_last  <= 1'b0;
        // a released bus must not keep showing the last word
        req_data  <= ~req_data;
    endtask
    task automatic recv(input int stall);
        int k;
        k = 0;
        q.delete();
        forever begin
            rsp_ready <= (k % (stall + 1)) == stall;
            @(posedge pclk);
            k++;
            if (rsp_valid === 1'b1 && rsp_ready) begin
                q.push_back(rsp_data);
                rj = rsp_reject;
                rr = rsp_reason;
                if (rsp_last === 1'b1)
                    break;
            end
            if (k > 2000) begin
                tmo = 1'b1;
                break;
            end
        end
        rsp_ready <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: dv/llsh_handler_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module llsh_handler_tb
    import llsh_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        req_valid, req_last, req_ready, rsp_valid, rsp_last, rsp_reject, rsp_ready;
    logic        lip_req, lip_login, port_monitoring, fan_busy, init_fail;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, req_data, rsp_data, rd;
    logic [7:0]  lip_byte3, lip_byte4;
    logic [1:0]  rsp_reason;
    int          miscompares, n_tests, lip_n;

    llsh_handler i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .req_valid(req_valid), .req_data(req_data), .req_last(req_last), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_last(rsp_last),
        .rsp_reject(rsp_reject), .rsp_reason(rsp_reason), .rsp_ready(rsp_ready),
        .lip_req(lip_req), .lip_login(lip_login), .lip_byte3(lip_byte3), .lip_byte4(lip_byte4),
        .port_monitoring(port_monitoring), .fan_busy(fan_busy), .init_fail(init_fail)
    );
    llsh_req_model i_req (
        .pclk(pclk), .req_ready(req_ready), .req_valid(req_valid), .req_data(req_data),
        .req_last(req_last), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_last(rsp_last),
        .rsp_reject(rsp_reject), .rsp_reason(rsp_reason), .rsp_ready(rsp_ready)
    );

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (lip_req === 1'b1)
            lip_n++;
    end

    task automatic final_report;
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int k;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (k >= 50) begin
            miscompares++;
            final_report;
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd, err);
    endtask
    task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, rd, err);
        chk(nm, e, rd);
    endtask
    task automatic got(input int stall);
        i_req.recv(stall);
        if (i_req.tmo) begin
            miscompares++;
            final_report;
        end
    endtask
    function automatic logic [31:0] pat(input int i);
        return 32'h5a00_0000 | 32'(i + 1);
    endfunction

    task automatic t_regs;
        rdchk("ctrl", 12'h000, 32'h0000_0003);
        rdchk("loop", 12'h008, 32'h0000_0001);
        apb(1'b0, 12'h040, 32'h0, rd, err);
        chk("unmapped err", 32'h1, {31'h0, err});
        wr(12'h104, 32'h1234_5678);
        rdchk("db word", 12'h104, 32'h1234_5678);
        wr(12'h104, 32'h0);
        $display("test regs done");
    endtask
    task automatic t_status;
        for (int i = 0; i < 12; i += 4)
            wr(12'h100 + 12'(i * 4), pat(i));
        i_req.send(32'h7200_0000, 32'h0, 1);
        got(2);
        chk("status len", 32'd42, 32'(i_req.q.size()));
        chk("status w0", 32'h0200_0000, i_req.q[0]);
        chk("status w1", 32'h0000_0001, i_req.q[1]);
        for (int i = 0; i < 40; i++)
            chk("status db", (i % 4 == 0 && i < 12) ? pat(i) : 32'h0, i_req.q[i + 2]);
        $display("test status done");
    endtask
    task automatic t_states;
        logic [31:0] e;
        for (int s = 2; s < 5; s++) begin
            wr(12'h008, {16'h0, 8'hf7, 8'(s)});
            i_req.send(32'h7200_0000, 32'h0, 1);
            got(0);
            e = {8'h0, (s == 2) ? 8'hf7 : 8'h00, 8'h0, 8'(s)};
            chk("state w1", e, i_req.q[1]);
            chk("public off", 32'h0, i_req.q[2]);
            chk("private off", 32'h0, i_req.q[6]);
            chk("map off", 32'h0, i_req.q[10]);
        end
        wr(12'h008, 32'h1);
        $display("test states done");
    endtask
    task automatic t_init(input logic [7:0] f, input logic fail);
        int k, n0;
        n0 = lip_n;
        i_req.send(32'h7000_0000, {8'hff, f, 8'hf8, 8'hef}, 2);
        k = 0;
        while (lip_req !== 1'b1 && k < 20) begin
            @(posedge pclk);
            k++;
        end
        chk("lip", {7'h0, 1'b1, 7'h0, f == 8'h01, 16'hf8ef},
            {7'h0, lip_req, 7'h0, lip_login, lip_byte3, lip_byte4});
        port_monitoring <= 1'b0;
        fan_busy        <= 1'b1;
        init_fail       <= fail;
        repeat (4) @(posedge pclk);
        port_monitoring <= 1'b1;
        repeat (6) @(posedge pclk);
        if (!fail)
            chk("early accept", 32'h0, {31'h0, rsp_valid});
        fan_busy <= 1'b0;
        got(1);
        chk("init len", 32'd2, 32'(i_req.q.size()));
        chk("init w0", 32'h0200_0000, i_req.q[0]);
        chk("init w1", fail ? 32'h2 : 32'h1, i_req.q[1]);
        chk("one lip", 32'(n0 + 1), 32'(lip_n));
        init_fail <= 1'b0;
        rdchk("loop after", 12'h008, fail ? 32'h3 : 32'h1);
        wr(12'h008, 32'h1);
        $display("test init done");
    endtask
    task automatic rej(input logic [31:0] c, input logic [31:0] w0, input logic [31:0] w1,
                       input int n, input logic [1:0] rs);
        int n0;
        n0 = lip_n;
        wr(12'h000, c);
        i_req.send(w0, w1, n);
        got(0);
        chk("reject", {29'h0, 1'b1, rs}, {29'h0, i_req.rj, i_req.rr});
        chk("reject word", 32'h0, i_req.q[0]);
        chk("no lip", 32'(n0), 32'(lip_n));
    endtask
    task automatic t_reject;
        rej(32'h3, 32'h7000_0000, 32'h0002_f7f7, 2, 2'h2);
        rej(32'h3, 32'h7000_0000, 32'h00ff_f7f7, 2, 2'h2);
        rej(32'h2, 32'h7000_0000, 32'h0000_f7f7, 2, 2'h1);
        rej(32'h3, 32'h7000_0000, 32'h0, 1, 2'h3);
        rej(32'h1, 32'h7200_0000, 32'h0, 1, 2'h1);
        wr(12'h000, 32'h3);
        rdchk("status", 12'h004, 32'h0005_0708);
        $display("test reject done");
    endtask

    initial begin
        repeat (50000) @(posedge pclk);
        miscompares++;
        final_report;
    end
    initial begin
        presetn         = 1'b0;
        psel            = 1'b0;
        penable         = 1'b0;
        pwrite          = 1'b0;
        paddr           = 12'h0;
        pwdata          = 32'h0;
        port_monitoring = 1'b1;
        fan_busy        = 1'b0;
        init_fail       = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs;
        t_status;
        t_states;
        t_init(8'h00, 1'b0);
        t_init(8'h01, 1'b0);
        t_init(8'h00, 1'b1);
        t_reject;
        final_report;
    end
endmodule
`default_nettype wire
